// *** bench/ascfg_chk.sv ***
// Port-level assertions for the serial configuration loader
`timescale 1ns/1ps
module ascfg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Loader pins
  input wire logic cfg_start_in_n,
  input wire logic chain_enable_out_n,
  input wire logic serial_cfg_clock_out,
  input wire logic serial_cfg_clock_oe_n,
  input wire logic flash_select_out_n,
  input wire logic flash_command_out,
  input wire logic cfg_status_in,
  input wire logic cfg_status_oe_n,
  input wire logic cfg_done_line_in,
  input wire logic cfg_done_line_oe_n,
  input wire logic user_io_oe_n,
  input wire logic init_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_err_done_low: assert property (!cfg_status_oe_n |-> !cfg_done_line_oe_n)
    else $error("done line released during error");
  // Six samples cover the pin synchroniser
  a_start_pulls_low: assert property ((!cfg_start_in_n) [*6] |->
    !cfg_status_oe_n && !cfg_done_line_oe_n && user_io_oe_n) else $error("start pin low, lines not pulled");
  a_begin_after: assert property ($fell(flash_select_out_n) |-> cfg_start_in_n && cfg_status_in)
    else $error("flash read began too early");
  a_done_needs_chain: assert property (cfg_done_line_oe_n |-> !chain_enable_out_n)
    else $error("done released before own image");
  a_init_on_line: assert property ($rose(init_start) |-> $past(cfg_done_line_in))
    else $error("init began with done line low");
  a_cmd_on_fall: assert property ($changed(flash_command_out) && !flash_select_out_n
    && !$past(flash_select_out_n) |-> !serial_cfg_clock_out) else $error("command changed on high clock");
  a_select_drives: assert property (!flash_select_out_n && !$past(flash_select_out_n)
    |-> !serial_cfg_clock_oe_n) else $error("flash selected, clock not driven");
  a_err_io_off: assert property (!cfg_status_oe_n |-> user_io_oe_n)
    else $error("user io enabled during error");
  c_error: cover property ($fell(cfg_status_oe_n));
  c_init: cover property ($rose(init_start));
  c_chain: cover property ($fell(chain_enable_out_n));
endmodule

bind ascfg_top ascfg_chk chk_u (.clk(clk), .rstn(rstn), .cfg_start_in_n(cfg_start_in_n),
  .chain_enable_out_n(chain_enable_out_n), .serial_cfg_clock_out(serial_cfg_clock_out),
  .serial_cfg_clock_oe_n(serial_cfg_clock_oe_n), .flash_select_out_n(flash_select_out_n),
  .flash_command_out(flash_command_out), .cfg_status_in(cfg_status_in), .cfg_status_oe_n(cfg_status_oe_n),
  .cfg_done_line_in(cfg_done_line_in), .cfg_done_line_oe_n(cfg_done_line_oe_n),
  .user_io_oe_n(user_io_oe_n), .init_start(init_start));

// *** bench/ascfg_flash_model.sv ***
// Behavioural serial flash holding the configuration image
`timescale 1ns/1ps
module ascfg_flash_model
  import ascfg_pkg::*;
(
  // Serial link from the loader
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic cmd,
  output logic dat,
  // Command bits captured
  output logic [31:0] cmd_seen
);
  logic [7:0] mem [0:255];
  int cnt = 0;
  initial dat = 1'b1;
  initial cmd_seen = 32'h0;
  always @(posedge sclk or posedge sel_n) begin
    if (sel_n) begin
      cnt <= 0;
    end else begin
      if (cnt < CMD_BITS) begin
        cmd_seen <= {cmd_seen[30:0], cmd};
      end
      cnt <= cnt + 1;
    end
  end
  // data out on falls; pull-up once deselected
  always @(negedge sclk or posedge sel_n) begin
    if (sel_n) begin
      dat <= 1'b1;
    end else if (cnt >= CMD_BITS) begin
      dat <= mem[((cnt - CMD_BITS) / 8) % 256][(cnt - CMD_BITS) % 8];
    end
  end
endmodule

// *** bench/ascfg_test.sv ***
// Self-checking bench for the serial configuration loader
`timescale 1ns/1ps
module ascfg_test
  import ascfg_pkg::*;
();
  localparam int RC = 20;
  localparam int HC = 20;
  localparam int FR = 4;
  logic clk;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic scheme_select = 1'b1;
  logic chain_enable_in_n = 1'b0;
  logic cfg_start_in_n = 1'b1;
  logic slv_clk = 1'b1;
  logic slv_dat = 1'b1;
  logic avs_waitrequest, irq, chain_enable_out_n, sclk_out, sclk_oe_n, sclk_w, data_w, sel_n, cmd_out, fl_dat;
  logic st_out, st_oe_n, st_w, dn_out, dn_oe_n, dn_w, user_io_oe_n, init_start;
  logic [31:0] avs_readdata, cmd_seen, rd;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h3A94;
  // Pull-ups on open-drain lines and the idle serial clock
  assign st_w = st_oe_n ? 1'b1 : st_out;
  assign dn_w = dn_oe_n ? 1'b1 : dn_out;
  assign sclk_w = sclk_oe_n ? slv_clk : sclk_out;
  assign data_w = scheme_select ? fl_dat : slv_dat;
  ascfg_top #(.FRAMES(FR), .RESTART_CYCLES(RC), .HOLD_CYCLES(HC)) dut_u (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .scheme_select(scheme_select),
    .cfg_start_in_n(cfg_start_in_n), .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
    .serial_cfg_clock_out(sclk_out), .serial_cfg_clock_oe_n(sclk_oe_n), .serial_cfg_clock_in(sclk_w),
    .cfg_serial_data_in(data_w), .flash_select_out_n(sel_n), .flash_command_out(cmd_out),
    .cfg_status_in(st_w), .cfg_status_out(st_out), .cfg_status_oe_n(st_oe_n), .cfg_done_line_in(dn_w),
    .cfg_done_line_out(dn_out), .cfg_done_line_oe_n(dn_oe_n), .user_io_oe_n(user_io_oe_n), .init_start(init_start));
  ascfg_flash_model flash_u (.sclk(sclk_w), .sel_n(sel_n), .cmd(cmd_out), .dat(fl_dat), .cmd_seen(cmd_seen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Ends when waitrequest falls; only the bench timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    check("waitrequest", avs_waitrequest, 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Random frames, each closed by its check byte; optional bad frame
  task automatic fill(input logic bad);
    logic [7:0] x;
    x = CHECK_SEED;
    for (int i = 0; i < 256; i++) begin
      if (i % 16 == 15) begin
        flash_u.mem[i] = x ^ {7'h00, bad && i == 31};
        x = CHECK_SEED;
      end else begin
        flash_u.mem[i] = 8'($random(seed));
        x = x ^ flash_u.mem[i];
      end
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return init_start;
      1: return st_oe_n;
      default: return sel_n;
    endcase
  endfunction
  task automatic wait_sig(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic rises(output int r);
    logic p;
    r = 0;
    p = sclk_out;
    repeat (80) begin
      @(posedge clk);
      if (sclk_out && !p) r++;
      p = sclk_out;
    end
  endtask
  // passive source, least significant bit first
  task automatic send_img();
    for (int i = 0; i < FR * 128; i++) begin
      @(posedge clk);
      slv_clk <= 1'b0;
      slv_dat <= flash_u.mem[i / 8][i % 8];
      repeat (4) @(posedge clk);
      slv_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    slv_dat <= 1'b1;
  endtask
  initial begin
    int r, lo;
    logic sel_hi;
    fill(1'b0);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0, rd);
    check("ctrl", rd, {28'h0, CTRL_RESET});
    bus(1'b0, REG_IRQ_MASK, 32'h0, rd);
    check("mask", rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h0000000F, rd);
    wait_sig(2, 1'b0);
    rises(r);
    check("fast rate", r, 80 / (2 * HALF_FAST));
    wait_sig(0, 1'b1);
    check("init", init_start, 1'b1);
    check("chain out", chain_enable_out_n, 1'b0);
    check("done oe", dn_oe_n, 1'b1);
    check("command", cmd_seen, {FLASH_READ_CMD, FLASH_START_ADDR});
    repeat (3) @(posedge clk);
    check("irq", irq, 1'b1);
    bus(1'b0, REG_IRQ_STAT, 32'h0, rd);
    check("events", rd, 32'h6);
    repeat (2) @(posedge clk);
    check("irq clear", irq, 1'b0);
    // Start pin reconfiguration, second frame corrupt
    fill(1'b1);
    cfg_start_in_n <= 1'b0;
    repeat (HC + 4) @(posedge clk);
    check("status low", st_oe_n, 1'b0);
    check("done low", dn_oe_n, 1'b0);
    check("io off", user_io_oe_n, 1'b1);
    cfg_start_in_n <= 1'b1;
    // Status must be released first, then pulled by the corrupt frame
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    check("error done", dn_oe_n, 1'b0);
    fill(1'b0);
    lo = 0;
    sel_hi = 1'b0;
    while (!st_oe_n && lo < 1000) begin
      @(posedge clk);
      lo++;
      sel_hi |= sel_n;
    end
    check("select pulse", sel_hi, 1'b1);
    check("restart wait", lo >= RC && lo <= RC + 16, 1'b1);
    wait_sig(0, 1'b1);
    check("retry", init_start, 1'b1);
    bus(1'b0, REG_IRQ_STAT, 32'h0, rd);
    check("events", rd, 32'hF);
    // Retry off, slow clock, software reconfiguration
    fill(1'b1);
    bus(1'b1, REG_CTRL, 32'h8, rd);
    wait_sig(2, 1'b0);
    rises(r);
    check("slow rate", r, 80 / (2 * HALF_SLOW));
    wait_sig(1, 1'b0);
    repeat (3 * RC) @(posedge clk);
    check("held", st_oe_n, 1'b0);
    fill(1'b0);
    cfg_start_in_n <= 1'b0;
    repeat (HC + 4) @(posedge clk);
    cfg_start_in_n <= 1'b1;
    wait_sig(0, 1'b1);
    check("restart", init_start, 1'b1);
    bus(1'b0, REG_IRQ_STAT, 32'h0, rd);
    check("events", rd, 32'h7);
    // Programming cable holds the loader off the flash
    chain_enable_in_n <= 1'b1;
    cfg_start_in_n <= 1'b0;
    repeat (HC + 4) @(posedge clk);
    check("cable hold", {sel_n, st_oe_n, user_io_oe_n}, 3'h5);
    // Cable lets go; passive slave, mask cleared by reset
    cfg_start_in_n <= 1'b1;
    scheme_select <= 1'b0;
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    send_img();
    check("slave idle", chain_enable_out_n, 1'b1);
    check("slave done", dn_oe_n, 1'b0);
    chain_enable_in_n <= 1'b0;
    send_img();
    wait_sig(0, 1'b1);
    check("slave chain", chain_enable_out_n, 1'b0);
    check("slave release", dn_oe_n, 1'b1);
    check("masked irq", irq, 1'b0);
    bus(1'b0, REG_IRQ_STAT, 32'h0, rd);
    check("slave events", rd, 32'h6);
    print_verdict();
  end
endmodule

// *** rtl/ascfg_pkg.sv ***
// Constants and types shared by the serial configuration loader
package ascfg_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Restart time-out and least pin-low time, in microseconds
  localparam int unsigned RESTART_US = 40;
  localparam int unsigned RESTART_CYC = RESTART_US * CLK_MHZ;
  localparam int unsigned HOLD_LOW_CYC = RESTART_US * CLK_MHZ;
  // Serial clock rates in MHz
  localparam int unsigned SCLK_FAST_MHZ = 20;
  localparam int unsigned SCLK_SLOW_MHZ = 10;
  // Half periods in system clocks; floor keeps the rate at or above the minimum
  localparam int unsigned HALF_FAST = CLK_MHZ / (2 * SCLK_FAST_MHZ);
  localparam int unsigned HALF_SLOW = CLK_MHZ / (2 * SCLK_SLOW_MHZ);
  // Flash read command and start address
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
  localparam int unsigned CMD_BITS = 32;
  // Frame layout: bytes, least significant bit first, frame closes with check byte
  localparam int unsigned FRAME_BYTES = 16;
  localparam logic [7:0] CHECK_SEED = 8'h00;

  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;
  // Control fields
  localparam int unsigned CTRL_AUTO = 0;
  localparam int unsigned CTRL_FAST = 1;
  localparam int unsigned CTRL_CONC = 2;
  localparam int unsigned CTRL_GO = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;
  // Event bits
  localparam int unsigned EV_ERR = 0;
  localparam int unsigned EV_OWN_DONE = 1;
  localparam int unsigned EV_CHAIN_DONE = 2;
  localparam int unsigned EV_RESTART = 3;
  localparam int unsigned EV_W = 4;

  typedef enum logic [2:0] {
    ASCFG_RESET,
    ASCFG_CMD,
    ASCFG_OWN,
    ASCFG_PASS,
    ASCFG_WAIT_DONE,
    ASCFG_ERROR,
    ASCFG_USER
  } ascfg_state_t;
endpackage

// *** rtl/ascfg_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ascfg_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin and synchronised level
  input wire logic pin_in,
  output logic level_out
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      meta_q <= pin_in;
      level_out <= meta_q;
    end
  end
endmodule

// *** rtl/ascfg_top.sv ***
// Active serial configuration loader with chain control and register bus
`timescale 1ns/1ps
module ascfg_top
  import ascfg_pkg::*;
#(
  parameter int unsigned FRAMES = 4,
  parameter int unsigned RESTART_CYCLES = RESTART_CYC,
  parameter int unsigned HOLD_CYCLES = HOLD_LOW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Straps and start pin
  input wire logic scheme_select,
  input wire logic cfg_start_in_n,
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  // Serial link
  output logic serial_cfg_clock_out,
  output logic serial_cfg_clock_oe_n,
  input wire logic serial_cfg_clock_in,
  input wire logic cfg_serial_data_in,
  output logic flash_select_out_n,
  output logic flash_command_out,
  // Open-drain status and done lines
  input wire logic cfg_status_in,
  output logic cfg_status_out,
  output logic cfg_status_oe_n,
  input wire logic cfg_done_line_in,
  output logic cfg_done_line_out,
  output logic cfg_done_line_oe_n,
  // User I/O release and init start
  output logic user_io_oe_n,
  output logic init_start
);
  localparam int unsigned BIT_W = $clog2(FRAMES * FRAME_BYTES * 8 + 1);
  localparam int unsigned TMR_W = $clog2((RESTART_CYCLES > HOLD_CYCLES ? RESTART_CYCLES : HOLD_CYCLES) + 2);

  // Synchronised pins
  logic start_n_s, ce_n_s, sclk_s, data_s, status_s, done_s, active_s;
  ascfg_sync #(.RESET_VAL(1'b1)) u_s0 (.clk(clk), .rstn(rstn), .pin_in(cfg_start_in_n), .level_out(start_n_s));
  ascfg_sync #(.RESET_VAL(1'b1)) u_s1 (.clk(clk), .rstn(rstn), .pin_in(chain_enable_in_n), .level_out(ce_n_s));
  ascfg_sync #(.RESET_VAL(1'b1)) u_s2 (.clk(clk), .rstn(rstn), .pin_in(serial_cfg_clock_in), .level_out(sclk_s));
  ascfg_sync #(.RESET_VAL(1'b0)) u_s3 (.clk(clk), .rstn(rstn), .pin_in(cfg_serial_data_in), .level_out(data_s));
  ascfg_sync #(.RESET_VAL(1'b0)) u_s4 (.clk(clk), .rstn(rstn), .pin_in(cfg_status_in), .level_out(status_s));
  ascfg_sync #(.RESET_VAL(1'b0)) u_s5 (.clk(clk), .rstn(rstn), .pin_in(cfg_done_line_in), .level_out(done_s));
  ascfg_sync #(.RESET_VAL(1'b0)) u_s6 (.clk(clk), .rstn(rstn), .pin_in(scheme_select), .level_out(active_s));

  ascfg_state_t state_q;
  logic [3:0] ctrl_q;
  logic [EV_W-1:0] irq_stat_q, irq_mask_q;
  logic [TMR_W-1:0] tmr_q, low_cnt_q;
  logic [BIT_W-1:0] bit_cnt_q;
  logic [5:0] cmd_cnt_q;
  logic [CMD_BITS-1:0] cmd_sh_q;
  logic [7:0] byte_q, check_q;
  logic [2:0] bit_in_byte_q;
  logic [7:0] byte_idx_q;
  logic [4:0] div_q;
  logic sclk_q, sclk_prev_q, own_done_q, conc_second_q, err_q, start_seen_q;
  logic fall, pin_fall, ext_rise, start_held, rx_bit_en;

  // Serial clock divider; the control register's fast bit picks the rate
  logic [4:0] half;
  assign half = ctrl_q[CTRL_FAST] ? 5'(HALF_FAST) : 5'(HALF_SLOW);
  logic master_run;
  assign master_run = active_s && (state_q == ASCFG_CMD || state_q == ASCFG_OWN || state_q == ASCFG_PASS);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_q <= 5'h00;
      sclk_q <= 1'b0;
    end else if (!master_run) begin
      div_q <= 5'h00;
      sclk_q <= 1'b0;
    end else if (div_q == half - 5'h01) begin
      div_q <= 5'h00;
      sclk_q <= ~sclk_q;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end
  assign fall = master_run && (div_q == half - 5'h01) && sclk_q;
  // Pin clock falls one cycle after the divider toggles
  assign pin_fall = serial_cfg_clock_out && !sclk_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Idle level of the pulled-up clock pin, so no false edge after reset
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end
  assign ext_rise = sclk_s && !sclk_prev_q;

  // slave only listens while enabled
  // Master reads at its falling toggle: synchroniser delay makes that the bit seen at the pin's rise
  assign rx_bit_en = active_s ? ((state_q == ASCFG_OWN) && fall)
                              : ((state_q == ASCFG_OWN) && ext_rise && !ce_n_s);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_cnt_q <= '0;
    end else if (start_n_s) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != TMR_W'(HOLD_CYCLES)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end
  assign start_held = (low_cnt_q == TMR_W'(HOLD_CYCLES));

  // Main sequence
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ASCFG_RESET;
      tmr_q <= '0;
      err_q <= 1'b0;
      start_seen_q <= 1'b0;
      conc_second_q <= 1'b0;
    end else begin
      if (start_held) begin
        start_seen_q <= 1'b1;
      end
      case (state_q)
        ASCFG_RESET: begin
          err_q <= 1'b0;
          conc_second_q <= 1'b0;
          // wait for start pin high and own release
          if (start_n_s && status_s) begin
            state_q <= active_s ? ASCFG_CMD : ASCFG_OWN;
            start_seen_q <= 1'b0;
          end
        end
        ASCFG_CMD: begin
          if (fall && cmd_cnt_q == 6'(CMD_BITS)) begin
            state_q <= ASCFG_OWN;
          end
        end
        ASCFG_OWN: begin
          if (err_q) begin
            state_q <= ASCFG_ERROR;
            tmr_q <= '0;
          end else if (own_done_q) begin
            state_q <= active_s ? ASCFG_PASS : ASCFG_WAIT_DONE;
          end
        end
        ASCFG_PASS: begin
          // chain error seen on the status line
          if (!status_s) begin
            state_q <= ASCFG_ERROR;
            tmr_q <= '0;
          end else if (done_s) begin
            state_q <= ASCFG_USER;
          end
        end
        ASCFG_WAIT_DONE: begin
          if (!status_s) begin
            state_q <= ASCFG_ERROR;
            tmr_q <= '0;
          end else if (done_s) begin
            state_q <= ASCFG_USER;
          end
        end
        ASCFG_ERROR: begin
          if (ctrl_q[CTRL_AUTO]) begin
            tmr_q <= tmr_q + 1'b1;
            if (tmr_q == TMR_W'(RESTART_CYCLES - 1)) begin
              state_q <= ASCFG_RESET;
            end
          end else if (start_seen_q) begin
            state_q <= ASCFG_RESET;
          end
        end
        ASCFG_USER: begin
          if (start_held || ctrl_q[CTRL_GO]) begin
            state_q <= ASCFG_RESET;
          end
        end
        default: state_q <= ASCFG_RESET;
      endcase
      if (state_q == ASCFG_OWN && rx_bit_en && bit_in_byte_q == 3'h7 &&
          byte_idx_q == 8'(FRAME_BYTES - 1) && check_q != {data_s, byte_q[7:1]}) begin
        err_q <= 1'b1;
      end
      // start pin low forces reset from any state but error
      if (!start_n_s && state_q != ASCFG_RESET && state_q != ASCFG_ERROR) begin
        state_q <= ASCFG_RESET;
      end
      if (state_q == ASCFG_PASS && own_done_q && ctrl_q[CTRL_CONC]) begin
        conc_second_q <= 1'b1;
      end
    end
  end

  // command bits shift on falling edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_sh_q <= {FLASH_READ_CMD, FLASH_START_ADDR};
      cmd_cnt_q <= 6'h00;
      flash_command_out <= 1'b1;
    end else if (state_q != ASCFG_CMD) begin
      cmd_sh_q <= {FLASH_READ_CMD, FLASH_START_ADDR};
      cmd_cnt_q <= 6'h00;
      flash_command_out <= 1'b1;
    end else if (cmd_cnt_q == 6'h00) begin
      // First bit set up before the first rising clock
      flash_command_out <= cmd_sh_q[CMD_BITS-1];
      cmd_sh_q <= {cmd_sh_q[CMD_BITS-2:0], 1'b0};
      cmd_cnt_q <= 6'h01;
    end else if (pin_fall && cmd_cnt_q != 6'(CMD_BITS)) begin
      flash_command_out <= cmd_sh_q[CMD_BITS-1];
      cmd_sh_q <= {cmd_sh_q[CMD_BITS-2:0], 1'b0};
      cmd_cnt_q <= cmd_cnt_q + 6'h01;
    end
  end

  // bytes assemble least significant bit first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      byte_q <= 8'h00;
      bit_in_byte_q <= 3'h0;
      byte_idx_q <= 8'h00;
      check_q <= CHECK_SEED;
      bit_cnt_q <= '0;
      own_done_q <= 1'b0;
    end else if (state_q == ASCFG_RESET) begin
      bit_in_byte_q <= 3'h0;
      byte_idx_q <= 8'h00;
      check_q <= CHECK_SEED;
      bit_cnt_q <= '0;
      own_done_q <= 1'b0;
    end else if (rx_bit_en && !own_done_q) begin
      byte_q <= {data_s, byte_q[7:1]};
      bit_in_byte_q <= bit_in_byte_q + 3'h1;
      bit_cnt_q <= bit_cnt_q + 1'b1;
      if (bit_in_byte_q == 3'h7) begin
        if (byte_idx_q == 8'(FRAME_BYTES - 1)) begin
          byte_idx_q <= 8'h00;
          check_q <= CHECK_SEED;
        end else begin
          byte_idx_q <= byte_idx_q + 8'h01;
          check_q <= check_q ^ {data_s, byte_q[7:1]};
        end
      end
      if (bit_cnt_q == BIT_W'(FRAMES * FRAME_BYTES * 8 - 1)) begin
        own_done_q <= 1'b1;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flash_select_out_n <= 1'b1;
      chain_enable_out_n <= 1'b1;
      serial_cfg_clock_out <= 1'b0;
      serial_cfg_clock_oe_n <= 1'b1;
      cfg_status_out <= 1'b0;
      cfg_status_oe_n <= 1'b0;
      cfg_done_line_out <= 1'b0;
      cfg_done_line_oe_n <= 1'b0;
      user_io_oe_n <= 1'b1;
      init_start <= 1'b0;
    end else begin
      // select low while reading; high in error pulses the flash reset
      flash_select_out_n <= !(master_run && !(state_q == ASCFG_PASS && !ctrl_q[CTRL_CONC]));
      chain_enable_out_n <= !own_done_q;
      serial_cfg_clock_out <= sclk_q;
      serial_cfg_clock_oe_n <= !master_run;
      // status driven low on error or reset
      // released once start pin is high again
      cfg_status_oe_n <= !(state_q == ASCFG_ERROR || !start_n_s);
      // done held low until own data done
      cfg_done_line_oe_n <= (own_done_q && state_q != ASCFG_ERROR && start_n_s) ? 1'b1 : 1'b0;
      // I/O released only in user mode
      user_io_oe_n <= (state_q != ASCFG_USER) || !start_n_s;
      init_start <= (state_q != ASCFG_USER) && done_s && own_done_q &&
                    (state_q == ASCFG_PASS || state_q == ASCFG_WAIT_DONE);
    end
  end

  // Interrupt events
  logic [EV_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_ERR] = (state_q != ASCFG_ERROR) && err_q;
    ev[EV_OWN_DONE] = rx_bit_en && bit_cnt_q == BIT_W'(FRAMES * FRAME_BYTES * 8 - 1);
    ev[EV_CHAIN_DONE] = init_start;
    ev[EV_RESTART] = (state_q == ASCFG_ERROR) && ctrl_q[CTRL_AUTO] && tmr_q == TMR_W'(RESTART_CYCLES - 1);
  end

  // Avalon slave: one wait cycle; read data loaded with the request so it stands in the answer cycle
  logic acc_q;
  logic hit_rd_stat;
  assign hit_rd_stat = avs_read && acc_q && avs_address == REG_IRQ_STAT;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      acc_q <= (avs_read || avs_write) && !acc_q;
      avs_waitrequest <= !((avs_read || avs_write) && !acc_q);
      ctrl_q[CTRL_GO] <= 1'b0;
      if (avs_write && acc_q) begin
        case (avs_address)
          REG_CTRL: ctrl_q <= avs_writedata[3:0];
          REG_IRQ_MASK: irq_mask_q <= avs_writedata[EV_W-1:0];
          default: ;
        endcase
      end
      if (avs_read && !acc_q) begin
        case (avs_address)
          REG_CTRL: avs_readdata <= {28'h0000000, ctrl_q};
          REG_STATUS: avs_readdata <= {21'h000000, own_done_q, done_s, status_s, !chain_enable_out_n,
                                       active_s, ce_n_s, start_n_s, 1'b0, state_q};
          REG_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_q | ev};
          REG_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      // New events win over the read clear
      irq_stat_q <= (hit_rd_stat ? '0 : irq_stat_q) | ev;
      irq <= |(((hit_rd_stat ? '0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end
endmodule
